// *** src/fsled_encoder.sv ***
// Status LED encoder for fieldbus, safety and service ports plus event severity handling
`timescale 1ns/1ps
`default_nettype none

module fsled_encoder
	import fsled_pkg::*;
#(
	parameter int unsigned FLASH_CYCLES = FLASH_CYC,
	parameter int unsigned RAPID_CYCLES = RAPID_CYC,
	parameter int unsigned WARN_CYCLES  = WARN_CYC
)(
	input  wire logic                          clk_sys,
	input  wire logic                          rst,
	input  wire fsled_pkg::fsled_safety_link_t safety_link_indicator_param,
	input  wire fsled_pkg::fsled_network_t     network_state_param,
	input  wire fsled_pkg::fsled_profile_t     safety_profile_state_param,
	input  wire fsled_pkg::fsled_port_t        service_port,
	input  wire fsled_pkg::fsled_port_t        fieldbus_port_in,
	input  wire fsled_pkg::fsled_port_t        fieldbus_port_out,
	input  wire fsled_pkg::fsled_sev_t         event_severity,
	input  wire fsled_pkg::fsled_react_t       fault_reaction,
	input  wire logic                          torque_off,
	input  wire logic                          stop_done,
	output var  fsled_pkg::fsled_leds_t        leds,
	output var  fsled_pkg::fsled_drive_t       drive
);
	import fsled_pkg::*;

	// ----------------------------------------------------------------
	// State record
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [TICK_W-1:0] flash_cnt;
		logic [TICK_W-1:0] rapid_cnt;
		logic [3:0]        slot;
		logic [3:0]        rapid_slot;
		logic              burst_phase;
		logic [2:0]        burst_cnt;
		logic              flash_ph;
		logic              rapid_ph;
		logic [TICK_W-1:0] warn_cnt;
		fsled_leds_t       leds;
		fsled_drive_t      drive;
	} fsled_state_t;

	fsled_state_t state_q;
	fsled_state_t state_d;

	// Inputs are stack states on this clock, so no synchronisers are needed.

	// Flash count that interleaves the rapid flashing, zero when none
	function automatic logic [2:0] burst_len(input fsled_profile_t p);
		unique case (p)
			FSLED_SP_ECOMM: burst_len = 3'd1;
			FSLED_SP_EAPP:  burst_len = 3'd2;
			FSLED_SP_EADDR: burst_len = 3'd3;
			FSLED_SP_EWDOG: burst_len = 3'd5;
			FSLED_SP_ECRC:  burst_len = 3'd6;
			default:        burst_len = 3'd0;
		endcase
	endfunction

	// Port activity encoding, used by the service port only
	function automatic logic act_led(input fsled_port_t p, input logic ph);
		act_led = p.link & (p.continuous | (p.packet & ph));
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		logic flash_tick;
		logic rapid_tick;
		logic single;
		logic [2:0] blen;
		logic burst_led;
		logic stopping;
		flash_tick = 1'b0;
		rapid_tick = 1'b0;
		single     = 1'b0;
		blen       = 3'd0;
		burst_led  = 1'b0;
		stopping   = 1'b0;
		state_d    = state_q;

		// Dividers give one-cycle enables; periods are parameters since none are fixed
		flash_tick = (state_q.flash_cnt == TICK_W'(FLASH_CYCLES - 1));
		rapid_tick = (state_q.rapid_cnt == TICK_W'(RAPID_CYCLES - 1));
		state_d.flash_cnt = flash_tick ? '0 : state_q.flash_cnt + 1'b1;
		state_d.rapid_cnt = rapid_tick ? '0 : state_q.rapid_cnt + 1'b1;
		if (flash_tick)
		begin
			state_d.flash_ph = ~state_q.flash_ph;
			state_d.slot     = (state_q.slot == FRAME_SLOTS - 4'h1) ? 4'h0
				: state_q.slot + 4'h1;
		end
		if (rapid_tick)
			state_d.rapid_ph = ~state_q.rapid_ph;
		// Single flash: one lit slot of an eight-slot frame
		single = (state_q.slot == 4'h0);

		// Burst sequencer: a rapid phase, then n slow flashes
		blen = burst_len(safety_profile_state_param);
		if (blen == 3'd0)
		begin
			state_d.burst_phase = 1'b0;
			state_d.burst_cnt   = 3'd0;
			state_d.rapid_slot  = 4'h0;
		end
		else if (!state_q.burst_phase && rapid_tick && state_q.rapid_ph)
		begin
			state_d.rapid_slot = state_q.rapid_slot + 4'h1;
			if (state_q.rapid_slot == RAPID_SLOTS - 4'h1)
			begin
				state_d.burst_phase = 1'b1;
				state_d.burst_cnt   = 3'd0;
				state_d.rapid_slot  = 4'h0;
			end
		end
		else if (state_q.burst_phase && flash_tick && state_q.flash_ph)
		begin
			if (state_q.burst_cnt == blen - 3'd1)
				state_d.burst_phase = 1'b0;
			else
				state_d.burst_cnt = state_q.burst_cnt + 3'd1;
		end
		burst_led = state_q.burst_phase ? state_q.flash_ph : state_q.rapid_ph;

		// Safety-over-fieldbus indicator
		unique case (safety_link_indicator_param)
			FSLED_SL_SETUP: state_d.leds.safety_link_led = single;
			FSLED_SL_RESET: state_d.leds.safety_link_led = state_q.rapid_ph;
			FSLED_SL_COMM:  state_d.leds.safety_link_led = state_q.flash_ph;
			FSLED_SL_DATA:  state_d.leds.safety_link_led = 1'b1;
			default:        state_d.leds.safety_link_led = 1'b0;
		endcase

		// Bus error and run LEDs from the network state
		unique case (network_state_param)
			FSLED_NW_NOLINK:
			begin
				state_d.leds.bus_error_led = 1'b1;
				state_d.leds.run_led       = 1'b0;
			end
			FSLED_NW_NOCONN:
			begin
				state_d.leds.bus_error_led = state_q.rapid_ph;
				state_d.leds.run_led       = 1'b0;
			end
			FSLED_NW_SETUP:
			begin
				state_d.leds.bus_error_led = state_q.rapid_ph;
				state_d.leds.run_led       = single;
			end
			FSLED_NW_DHCP:
			begin
				state_d.leds.bus_error_led = state_q.rapid_ph;
				state_d.leds.run_led       = ~single;
			end
			FSLED_NW_EXPECT:
			begin
				state_d.leds.bus_error_led = state_q.rapid_ph;
				state_d.leds.run_led       = state_q.flash_ph;
			end
			default:
			begin
				state_d.leds.bus_error_led = 1'b0;
				state_d.leds.run_led       = 1'b1;
			end
		endcase

		// Safety-profile LED
		unique case (safety_profile_state_param)
			FSLED_SP_INIT:   state_d.leds.safety_profile_led = 1'b0;
			FSLED_SP_PARAM:  state_d.leds.safety_profile_led = state_q.flash_ph;
			FSLED_SP_NORMAL: state_d.leds.safety_profile_led = 1'b1;
			default:         state_d.leds.safety_profile_led = burst_led;
		endcase

		// Service and fieldbus ports
		state_d.leds.service_act_led  = act_led(service_port, state_q.flash_ph);
		state_d.leds.service_link_led = service_port.link;
		state_d.leds.input_port_link_led = fieldbus_port_in.link
			& (~fieldbus_port_in.packet | state_q.flash_ph);
		state_d.leds.output_port_link_led = fieldbus_port_out.link
			& (~fieldbus_port_out.packet | state_q.flash_ph);
		state_d.leds.input_port_act_led = fieldbus_port_in.link
			& fieldbus_port_in.packet & state_q.flash_ph;
		state_d.leds.output_port_act_led = fieldbus_port_out.link
			& fieldbus_port_out.packet & state_q.flash_ph;

		// Severity: warning timer escalates to fault; messages only report
		state_d.drive.report = (event_severity != FSLED_EV_NONE);
		if (event_severity == FSLED_EV_WARN)
		begin
			if (state_q.warn_cnt != TICK_W'(WARN_CYCLES - 1))
				state_d.warn_cnt = state_q.warn_cnt + 1'b1;
		end
		else
			state_d.warn_cnt = '0;

		// Faults latch until the severity input drops back
		if (event_severity == FSLED_EV_FAULT
			|| (event_severity == FSLED_EV_WARN
			&& state_q.warn_cnt == TICK_W'(WARN_CYCLES - 1)))
			state_d.drive.fault = 1'b1;
		else if (event_severity == FSLED_EV_NONE)
			state_d.drive.fault = 1'b0;

		// Fault reaction: new fault picks disable or a stop ramp
		stopping = state_q.drive.stop_active;
		if (state_d.drive.fault && !state_q.drive.fault)
		begin
			if (stopping || torque_off)
			begin
				// A stop cannot be trusted once hit again; drop the power unit
				state_d.drive.stop_active   = 1'b0;
				state_d.drive.ebrake        = 1'b0;
				state_d.drive.power_disable = 1'b1;
			end
			else if (fault_reaction == FSLED_RX_DISABLE)
				state_d.drive.power_disable = 1'b1;
			else
			begin
				state_d.drive.stop_active = 1'b1;
				state_d.drive.ebrake      = (fault_reaction == FSLED_RX_EBRAKE);
			end
		end
		else if (stopping && (torque_off || stop_done))
		begin
			state_d.drive.stop_active   = 1'b0;
			state_d.drive.ebrake        = 1'b0;
			state_d.drive.power_disable = 1'b1;
		end
		else if (!state_d.drive.fault)
			state_d.drive.power_disable = 1'b0;
	end

	// ----------------------------------------------------------------
	// Register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			state_q <= '0;
		else
			state_q <= state_d;
	end

	assign leds  = state_q.leds;
	assign drive = state_q.drive;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence nolink_s;
		network_state_param == FSLED_NW_NOLINK;
	endsequence

	// A stop ramp still running after its fault has been cleared
	sequence stop_running_s;
		drive.stop_active && !drive.fault;
	endsequence

	// A fresh fault that asks for a quick stop
	sequence stop_request_s;
		!drive.fault && !drive.stop_active && !torque_off
		&& event_severity == FSLED_EV_FAULT && fault_reaction == FSLED_RX_QSTOP;
	endsequence

	sl_data_on_a: assert property (
		safety_link_indicator_param == FSLED_SL_DATA |=> leds.safety_link_led)
		else $error("safety link led not lit with process data");
	sl_none_off_a: assert property (
		safety_link_indicator_param == FSLED_SL_NONE |=> !leds.safety_link_led)
		else $error("safety link led lit with no communication");
	bus_err_on_a: assert property (
		nolink_s |=> leds.bus_error_led && !leds.run_led)
		else $error("bus error led wrong with no network");
	run_steady_a: assert property (
		network_state_param == FSLED_NW_RUN |=> leds.run_led && !leds.bus_error_led)
		else $error("run led not steady when connected");
	prof_init_a: assert property (
		safety_profile_state_param == FSLED_SP_INIT |=> !leds.safety_profile_led)
		else $error("profile led lit during init");
	prof_normal_a: assert property (
		safety_profile_state_param == FSLED_SP_NORMAL |=> leds.safety_profile_led)
		else $error("profile led not lit in normal operation");
	svc_act_off_a: assert property (
		!service_port.link |=> !leds.service_act_led)
		else $error("service activity led lit without connection");
	svc_act_on_a: assert property (
		service_port.link && service_port.continuous |=> leds.service_act_led)
		else $error("service activity led dark in continuous exchange");
	fb_link_off_a: assert property (
		!fieldbus_port_out.link |=> !leds.output_port_link_led)
		else $error("fieldbus link led lit without connection");
	fb_link_on_a: assert property (
		fieldbus_port_in.link && !fieldbus_port_in.packet |=> leds.input_port_link_led)
		else $error("fieldbus link led not steady with connection");
	svc_link_a: assert property (
		1'b1 |=> leds.service_link_led == $past(service_port.link))
		else $error("service link led does not follow link");
	fb_act_a: assert property (
		!fieldbus_port_in.link |=> !leds.input_port_act_led)
		else $error("activity led lit without link");
	fault_disable_a: assert property (
		!drive.fault && !drive.stop_active && event_severity == FSLED_EV_FAULT
		&& fault_reaction == FSLED_RX_DISABLE && !torque_off |=> drive.power_disable)
		else $error("fault did not disable power unit");
	fault_stop_a: assert property (
		stop_request_s |=> drive.stop_active && !drive.ebrake)
		else $error("fault did not start the quick stop");
	stop_refault_a: assert property (
		stop_running_s ##0 event_severity == FSLED_EV_FAULT
		|=> !drive.stop_active && drive.power_disable)
		else $error("stop not aborted by a new fault");
	stop_abort_a: assert property (
		drive.stop_active && torque_off |=> !drive.stop_active && drive.power_disable)
		else $error("stop not aborted on torque off");
	msg_no_fault_a: assert property (
		!drive.fault && event_severity == FSLED_EV_MSG |=> !drive.fault && drive.report)
		else $error("message raised a fault");

endmodule // fsled_encoder

`default_nettype wire

// *** src/fsled_pkg.sv ***
// Package of states, pattern timing and carrier types for the status LED encoder
package fsled_pkg;

	// ----------------------------------------------------------------
	// Pattern timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ          = 20_000_000;
	localparam int unsigned FLASH_MS        = 200;
	localparam int unsigned RAPID_MS        = 50;
	localparam int unsigned FLASH_CYC       = CLK_HZ / 1000 * FLASH_MS;
	localparam int unsigned RAPID_CYC       = CLK_HZ / 1000 * RAPID_MS;
	localparam int unsigned WARN_MS         = 1000;
	localparam int unsigned WARN_CYC        = CLK_HZ / 1000 * WARN_MS;
	localparam int unsigned TICK_W          = 25; // Must hold the whole warning span
	localparam logic [3:0]  FRAME_SLOTS     = 4'h8;
	localparam logic [3:0]  RAPID_SLOTS     = 4'h8;

	// ----------------------------------------------------------------
	// Safety-over-fieldbus states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		FSLED_SL_NONE,
		FSLED_SL_SETUP,
		FSLED_SL_RESET,
		FSLED_SL_COMM,
		FSLED_SL_DATA
	} fsled_safety_link_t;

	// Network states
	typedef enum logic [2:0] {
		FSLED_NW_NOLINK,
		FSLED_NW_NOCONN,
		FSLED_NW_SETUP,
		FSLED_NW_DHCP,
		FSLED_NW_EXPECT,
		FSLED_NW_RUN
	} fsled_network_t;

	// Safety-profile states
	typedef enum logic [2:0] {
		FSLED_SP_INIT,
		FSLED_SP_PARAM,
		FSLED_SP_NORMAL,
		FSLED_SP_ECOMM,
		FSLED_SP_EAPP,
		FSLED_SP_EADDR,
		FSLED_SP_EWDOG,
		FSLED_SP_ECRC
	} fsled_profile_t;

	// Event severity
	typedef enum logic [1:0] {
		FSLED_EV_NONE,
		FSLED_EV_MSG,
		FSLED_EV_WARN,
		FSLED_EV_FAULT
	} fsled_sev_t;

	// Fault reaction
	typedef enum logic [1:0] {
		FSLED_RX_DISABLE,
		FSLED_RX_QSTOP,
		FSLED_RX_EBRAKE
	} fsled_react_t;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic link;
		logic packet;
		logic continuous;
	} fsled_port_t;

	typedef struct packed {
		logic safety_link_led;
		logic bus_error_led;
		logic run_led;
		logic safety_profile_led;
		logic service_link_led;
		logic service_act_led;
		logic input_port_link_led;
		logic output_port_link_led;
		logic input_port_act_led;
		logic output_port_act_led;
	} fsled_leds_t;

	typedef struct packed {
		logic power_disable;
		logic stop_active;
		logic ebrake;
		logic fault;
		logic report;
	} fsled_drive_t;

endpackage : fsled_pkg

// *** verification/fsled_ctrl_model.sv ***
// Behavioural network controller model driving state and port activity levels
`timescale 1ns/1ps
`default_nettype none

module fsled_ctrl_model
	import fsled_pkg::*;
(
	input  wire logic                      clk_sys,
	input  wire fsled_pkg::fsled_network_t net_cmd,
	input  wire logic [1:0]                act_cmd,
	output var  fsled_pkg::fsled_network_t network_state_param,
	output var  fsled_pkg::fsled_port_t    fieldbus_port_in,
	output var  fsled_pkg::fsled_port_t    fieldbus_port_out
);
	import fsled_pkg::*;

	// ----------------------------------------------------------------
	// Drive
	// ----------------------------------------------------------------
	// Known levels from time zero so the encoder never samples unknowns
	initial
	begin
		network_state_param = FSLED_NW_NOLINK;
		fieldbus_port_in    = '0;
		fieldbus_port_out   = '0;
	end

	// Updates on the falling edge, clear of the sampling edge
	always @(negedge clk_sys)
	begin
		network_state_param <= net_cmd;
		fieldbus_port_in    <= '{act_cmd != 2'h0, act_cmd[1], act_cmd == 2'h3};
		fieldbus_port_out   <= '{act_cmd != 2'h0, act_cmd[1], act_cmd == 2'h3};
	end
endmodule // fsled_ctrl_model

`default_nettype wire

// *** verification/tb_fieldbus_status_led_encoder.sv ***
// Self-checking testbench for the status LED encoder
`timescale 1ns/1ps
`default_nettype none

module tb_fieldbus_status_led_encoder;
	import fsled_pkg::*;
	// ----------------------------------------------------------------
	// Setup
	// ----------------------------------------------------------------
	localparam int F = 4;
	localparam int R = 2;
	localparam int W = 16 * F;
	logic               clk_sys = 1'b0;
	logic               rst     = 1'b1;
	fsled_safety_link_t sl;
	fsled_network_t     net_cmd;
	logic [1:0]         act_cmd;
	fsled_network_t     nw;
	fsled_profile_t     sp;
	fsled_port_t        svc, fb_in, fb_out;
	fsled_sev_t         sev;
	fsled_react_t       react;
	logic               torque_off, stop_done;
	fsled_leds_t        leds;
	fsled_drive_t       drive;
	logic [9:0]         lv;
	int                 errors = 0;
	int                 n_compared = 0;
	int                 hi, rises;

	assign lv = leds;
	always #25 clk_sys = ~clk_sys;

	fsled_ctrl_model i_ctrl (.clk_sys(clk_sys), .net_cmd(net_cmd), .act_cmd(act_cmd),
		.network_state_param(nw), .fieldbus_port_in(fb_in), .fieldbus_port_out(fb_out));

	fsled_encoder #(.FLASH_CYCLES(F), .RAPID_CYCLES(R), .WARN_CYCLES(8)) i_dut (
		.clk_sys(clk_sys), .rst(rst), .safety_link_indicator_param(sl),
		.network_state_param(nw), .safety_profile_state_param(sp), .service_port(svc),
		.fieldbus_port_in(fb_in), .fieldbus_port_out(fb_out), .event_severity(sev),
		.fault_reaction(react), .torque_off(torque_off), .stop_done(stop_done),
		.leds(leds), .drive(drive));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			errors++;
			$display("BAD %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test;
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	// Lit cycles and rising edges over a window; phase free as the window spans whole periods
	task automatic pat(input int b, input int len, input int exp_hi, input int exp_rises);
		logic prev;
		cyc(3);
		prev  = lv[b];
		hi    = 0;
		rises = 0;
		repeat (len)
		begin
			@(negedge clk_sys);
			hi += int'(lv[b]);
			rises += int'(lv[b] && !prev);
			prev = lv[b];
		end
		if (exp_hi >= 0)
			check(hi, exp_hi);
		check(rises, exp_rises);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_safety_link;
		sl = FSLED_SL_NONE;  pat(9, W, 0, 0);
		sl = FSLED_SL_SETUP; pat(9, W, W/8, 2);
		sl = FSLED_SL_RESET; pat(9, W, W/2, W/2/R);
		sl = FSLED_SL_COMM;  pat(9, W, W/2, W/2/F);
		sl = FSLED_SL_DATA;  pat(9, W, W, 0);
	endtask

	task automatic t_network;
		net_cmd = FSLED_NW_NOLINK; pat(8, W, W, 0);
		pat(7, W, 0, 0);
		net_cmd = FSLED_NW_NOCONN; pat(8, W, W/2, W/2/R);
		net_cmd = FSLED_NW_SETUP;  pat(7, W, W/8, 2);
		net_cmd = FSLED_NW_DHCP;   pat(7, W, W*7/8, 2);
		net_cmd = FSLED_NW_EXPECT; pat(7, W, W/2, W/2/F);
		net_cmd = FSLED_NW_RUN;    pat(7, W, W, 0);
		pat(8, W, 0, 0);
	endtask

	// Burst period is eight rapid pulses then n slow flashes
	task automatic t_profile;
		fsled_profile_t codes [5] = '{FSLED_SP_ECOMM, FSLED_SP_EAPP, FSLED_SP_EADDR,
			FSLED_SP_EWDOG, FSLED_SP_ECRC};
		int n [5] = '{1, 2, 3, 5, 6};
		sp = FSLED_SP_INIT;   pat(6, W, 0, 0);
		sp = FSLED_SP_PARAM;  pat(6, W, W/2, W/2/F);
		sp = FSLED_SP_NORMAL; pat(6, W, W, 0);
		foreach (codes[i])
		begin
			sp = codes[i];
			// The frame running at the change is irregular; let one frame pass first
			cyc(16*R + 2*F*n[i]);
			pat(6, 16*R + 2*F*n[i], -1, 8 + n[i]);
		end
	endtask

	task automatic t_ports;
		svc = '{1'b0, 1'b0, 1'b0}; pat(5, W, 0, 0);
		pat(4, W, 0, 0);
		svc = '{1'b1, 1'b0, 1'b0}; pat(5, W, W, 0);
		svc = '{1'b1, 1'b1, 1'b0}; pat(4, W, W/2, W/2/F);
		svc = '{1'b1, 1'b1, 1'b1}; pat(4, W, W, 0);
		act_cmd = 2'h0; pat(3, W, 0, 0);
		pat(1, W, 0, 0);
		act_cmd = 2'h1; pat(3, W, W, 0);
		pat(2, W, W, 0);
		pat(0, W, 0, 0);
		act_cmd = 2'h2; pat(3, W, W/2, W/2/F);
		pat(1, W, W/2, W/2/F);
		pat(0, W, W/2, W/2/F);
	endtask

	task automatic t_events;
		sev = FSLED_EV_MSG; cyc(3);
		check(drive.report, 1);
		check(drive.fault, 0);
		sev = FSLED_EV_WARN; cyc(5);
		check(drive.fault, 0);
		cyc(7);
		check(drive.fault, 1);
		sev = FSLED_EV_NONE; cyc(3);
		check(drive.fault, 0);
	endtask

	// Each fault reaction, then aborts by torque off, ramp end and a fresh fault
	task automatic t_faults;
		sev = FSLED_EV_FAULT; react = FSLED_RX_DISABLE; cyc(2);
		check(drive.power_disable, 1);
		sev = FSLED_EV_NONE; cyc(3);
		sev = FSLED_EV_FAULT; react = FSLED_RX_QSTOP; cyc(2);
		check(drive.stop_active, 1);
		torque_off = 1'b1; cyc(2);
		check(drive.stop_active, 0);
		check(drive.power_disable, 1);
		sev = FSLED_EV_NONE; torque_off = 1'b0; cyc(3);
		sev = FSLED_EV_FAULT; react = FSLED_RX_EBRAKE; cyc(2);
		check(drive.ebrake, 1);
		stop_done = 1'b1; cyc(2);
		check(drive.power_disable, 1);
		check(drive.ebrake, 0);
		sev = FSLED_EV_NONE; stop_done = 1'b0; cyc(3);
		sev = FSLED_EV_FAULT; react = FSLED_RX_QSTOP; cyc(2);
		check(drive.ebrake, 0);
		sev = FSLED_EV_NONE; cyc(2);
		check(drive.stop_active, 1);
		sev = FSLED_EV_FAULT; cyc(2);
		check(drive.stop_active, 0);
		check(drive.power_disable, 1);
		sev = FSLED_EV_NONE; cyc(3);
	endtask

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial
	begin
		sl = FSLED_SL_NONE; net_cmd = FSLED_NW_NOLINK; act_cmd = 2'h0;
		sp = FSLED_SP_INIT; svc = '0; sev = FSLED_EV_NONE; react = FSLED_RX_DISABLE;
		torque_off = 1'b0; stop_done = 1'b0;
		cyc(4);
		rst = 1'b0;
		t_safety_link();
		t_network();
		t_profile();
		t_ports();
		t_events();
		t_faults();
		end_of_test();
	end

	// Runs are near 2600 cycles; this bound only cuts a hang
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		errors++;
		$display("BAD %0t watchdog expired", $time);
		end_of_test();
	end
endmodule // tb_fieldbus_status_led_encoder

`default_nettype wire
